/* File: rtl/ref_sel_consts.svh */
// Purpose: offsets, field positions, reset values and tick figures of the reference input selector
// Assumes: register indices are word indices, byte address is four times the index
// Notes:   definitions only
`ifndef REF_SEL_CONSTS_SVH
`define REF_SEL_CONSTS_SVH

`define IDX_SRC_CTRL    8'h20
`define IDX_SEL_MODE    8'h21
`define IDX_HOLDOFF     8'h22
`define IDX_TICK_DIV    8'h23
`define IDX_STATUS      8'h28

`define BIT_SRC_INT     0
`define BIT_HO_DISABLE  1
`define BIT_INT_PICK    0
`define LSB_MODE        2
`define BIT_REVERT      4
`define LSB_TICK_DIV    6

`define RST_SRC_INT     1'h0
`define RST_HO_DISABLE  1'h1
`define RST_INT_PICK    1'h0
`define RST_MODE        2'h0
`define RST_REVERT      1'h0
`define RST_HOLDOFF     8'h80
`define RST_TICK_DIV    2'h2

`define TICK_BASE_LOG2  15
`define HTRANS_NONSEQ   2'h2

`endif

/* File: rtl/ref_sel_pkg.sv */
// Purpose: shared types of the reference input selector
// Assumes: nothing
// Notes:   constants live in ref_sel_consts.svh
package ref_sel_pkg;

	typedef enum logic [1:0]
	{
		MODE_MANUAL     = 2'b00,
		MODE_AUTO       = 2'b01,
		MODE_SHORT_HOLD = 2'b10,
		MODE_AUTO_HOLD  = 2'b11
	} ref_mode_t;

	typedef enum logic [0:0]
	{
		ST_STEADY  = 1'b0,
		ST_HOLDOFF = 1'b1
	} auto_state_t;

endpackage

/* File: rtl/holdoff_tick_divider.sv */
// Purpose: divides the clock by 2^(base+0/1/2) into one-cycle tick pulses
// Assumes: div_sel 11 behaves as 10
// Notes:   base is a parameter so simulation can shorten the tick
`timescale 1ns/1ns
`include "ref_sel_consts.svh"

module holdoff_tick_divider #(
	parameter int BASE_LOG2 = `TICK_BASE_LOG2
) (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic [1:0] div_sel_in,
	output logic            tick_out
);
	localparam int W = BASE_LOG2 + 2;

	initial
	begin
		if (BASE_LOG2 < 1 || BASE_LOG2 > 28)
			$error("holdoff_tick_divider: BASE_LOG2 out of range");
	end

	logic [W-1:0] cnt_q;
	logic [W-1:0] limit;

	always_comb
	begin
		limit = ({{(W-1){1'b0}}, 1'b1} << (BASE_LOG2 + ((div_sel_in == 2'h0) ? 0 : (div_sel_in == 2'h1) ? 1 : 2)))
			- {{(W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			cnt_q <= '0;
		else if (cnt_q >= limit)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			tick_out <= 1'b0;
		else
			tick_out <= (cnt_q >= limit);
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	tick_single_a: assert property (tick_out |=> !tick_out)
		else $error("hold-off tick lasted more than one cycle");
endmodule

/* File: rtl/holdoff_counter.sv */
// Purpose: 8-bit hold-off down-counter stepped by the divided tick
// Assumes: start and stop come from the selector state machine
// Notes:   keeps reloading after each zero transition until stopped
`timescale 1ns/1ns

module holdoff_counter #(
	parameter int CNT_W = 8
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             start_in,
	input  wire logic             stop_in,
	input  wire logic             tick_in,
	input  wire logic [CNT_W-1:0] setting_in,
	output logic      [CNT_W-1:0] count_out,
	output logic                  running_out,
	output logic                  zero_out
);
	initial
	begin
		if (CNT_W < 1)
			$error("holdoff_counter: CNT_W must be positive");
	end

	logic hit_zero;

	// a setting of zero expires on the first tick
	assign hit_zero = running_out && tick_in && (count_out <= {{(CNT_W-1){1'b0}}, 1'b1});

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			running_out <= 1'b0;
		else if (stop_in)
			running_out <= 1'b0;
		else if (start_in)
			running_out <= 1'b1;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			count_out <= '0;
		else if (start_in || hit_zero)
			count_out <= setting_in;
		else if (running_out && tick_in)
			count_out <= count_out - {{(CNT_W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			zero_out <= 1'b0;
		else
			zero_out <= hit_zero && !stop_in;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	reload_zero_a: assert property (zero_out |-> count_out == $past(setting_in))
		else $error("hold-off counter did not reload on zero");
	step_down_a: assert property (running_out && tick_in && !start_in && !stop_in && count_out > 8'h01
		|=> count_out == $past(count_out) - 8'h01)
		else $error("hold-off counter did not step down on tick");
endmodule

/* File: rtl/reference_input_selector.sv */
// Purpose: picks which of two reference inputs feeds the first PLL, with AHB-Lite registers
// Assumes: los_in and the select pin are synchronous to clk_in; the monitor clears los_in on revalidation
// Notes:   reads take one wait state, writes none; response is always OKAY
`timescale 1ns/1ns
`include "ref_sel_consts.svh"

module reference_input_selector #(
	parameter int       TICK_BASE_LOG2  = `TICK_BASE_LOG2,
	parameter bit [0:0] PREFERRED_INPUT = 1'b0
) (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic             hreadyout_out,
	output logic             hresp_out,
	output logic [31:0]      hrdata_out,
	input  wire logic        external_reference_pick_pin_in,
	input  wire logic [1:0]  los_in,
	output logic             ref_select_out,
	output logic             holdover_out
);
	initial
	begin
		if (TICK_BASE_LOG2 < 1 || TICK_BASE_LOG2 > 28)
			$error("reference_input_selector: TICK_BASE_LOG2 out of range");
	end

	// software registers
	logic                   src_int_q;
	logic                   manual_holdover_disable_q;
	logic                   int_pick_q;
	ref_sel_pkg::ref_mode_t reference_selection_mode_q;
	logic                   revertive_switch_enable_q;
	logic [7:0]             holdoff_count_setting_q;
	logic [1:0]             holdoff_tick_divider_q;

	// bus state
	logic        wr_q;
	logic        rd_q;
	logic [31:0] addr_q;

	// selection state
	ref_sel_pkg::auto_state_t state_q;
	logic [1:0]               los_prev_q;
	logic                     auto_mode;
	logic                     manual_pick;
	logic                     other;
	logic                     revalidated;
	logic                     tick;
	logic                     cnt_start;
	logic                     cnt_stop;
	logic                     cnt_zero;
	logic                     cnt_running;
	logic [7:0]               cnt_value;
	logic                     addr_ok;

	function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] idx);
		reg_hit = (addr == {22'h000000, idx, 2'h0});
	endfunction

	assign hresp_out     = 1'b0;
	assign hreadyout_out = !rd_q;
	assign addr_ok       = hsel_in && hready_in && (htrans_in == `HTRANS_NONSEQ);

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			addr_q <= 32'h00000000;
		end
		else if (addr_ok)
		begin
			wr_q   <= hwrite_in && (hsize_in == 3'h2);
			rd_q   <= !hwrite_in;
			addr_q <= haddr_in;
		end
		else
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end
	end

	// reads wait one cycle so a read right after a write sees the new value
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			hrdata_out <= 32'h00000000;
		else if (rd_q)
		begin
			hrdata_out <= 32'h00000000;
			if (reg_hit(addr_q, `IDX_SRC_CTRL))
			begin
				hrdata_out[`BIT_SRC_INT]    <= src_int_q;
				hrdata_out[`BIT_HO_DISABLE] <= manual_holdover_disable_q;
			end
			if (reg_hit(addr_q, `IDX_SEL_MODE))
			begin
				hrdata_out[`BIT_INT_PICK]             <= int_pick_q;
				hrdata_out[`LSB_MODE+1:`LSB_MODE]     <= reference_selection_mode_q;
				hrdata_out[`BIT_REVERT]               <= revertive_switch_enable_q;
			end
			if (reg_hit(addr_q, `IDX_HOLDOFF))
				hrdata_out[7:0] <= holdoff_count_setting_q;
			if (reg_hit(addr_q, `IDX_TICK_DIV))
				hrdata_out[`LSB_TICK_DIV+1:`LSB_TICK_DIV] <= holdoff_tick_divider_q;
			if (reg_hit(addr_q, `IDX_STATUS))
				hrdata_out[15:0] <= {cnt_value, 2'h0, los_in, cnt_running, state_q, holdover_out, ref_select_out};
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			src_int_q                  <= `RST_SRC_INT;
			manual_holdover_disable_q  <= `RST_HO_DISABLE;
			int_pick_q                 <= `RST_INT_PICK;
			reference_selection_mode_q <= ref_sel_pkg::ref_mode_t'(`RST_MODE);
			revertive_switch_enable_q  <= `RST_REVERT;
			holdoff_count_setting_q    <= `RST_HOLDOFF;
			holdoff_tick_divider_q     <= `RST_TICK_DIV;
		end
		else if (wr_q)
		begin
			if (reg_hit(addr_q, `IDX_SRC_CTRL))
			begin
				src_int_q                 <= hwdata_in[`BIT_SRC_INT];
				manual_holdover_disable_q <= hwdata_in[`BIT_HO_DISABLE];
			end
			if (reg_hit(addr_q, `IDX_SEL_MODE))
			begin
				int_pick_q                 <= hwdata_in[`BIT_INT_PICK];
				reference_selection_mode_q <= ref_sel_pkg::ref_mode_t'(hwdata_in[`LSB_MODE+1:`LSB_MODE]);
				revertive_switch_enable_q  <= hwdata_in[`BIT_REVERT];
			end
			if (reg_hit(addr_q, `IDX_HOLDOFF))
				holdoff_count_setting_q <= hwdata_in[7:0];
			if (reg_hit(addr_q, `IDX_TICK_DIV))
				holdoff_tick_divider_q <= hwdata_in[`LSB_TICK_DIV+1:`LSB_TICK_DIV];
		end
	end

	// automatic only when the mode field governs and its low bit is set
	assign auto_mode   = manual_holdover_disable_q && reference_selection_mode_q[0];
	assign manual_pick = src_int_q ? int_pick_q : external_reference_pick_pin_in;
	assign other       = !ref_select_out;
	assign revalidated = los_prev_q[other] && !los_in[other];

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			los_prev_q <= 2'h0;
		else
			los_prev_q <= los_in;
	end

	holdoff_tick_divider #(
		.BASE_LOG2 (TICK_BASE_LOG2)
	) u_tick (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.div_sel_in (holdoff_tick_divider_q),
		.tick_out   (tick)
	);

	// the counter stops as soon as the mode leaves automatic, so a late zero cannot switch
	holdoff_counter #(
		.CNT_W (8)
	) u_holdoff (
		.clk_in      (clk_in),
		.rst_n_in    (rst_n_in),
		.start_in    (cnt_start),
		.stop_in     (cnt_stop),
		.tick_in     (tick),
		.setting_in  (holdoff_count_setting_q),
		.count_out   (cnt_value),
		.running_out (cnt_running),
		.zero_out    (cnt_zero)
	);

	// hold-off ends when the selected input recovers or when expiry finds a usable target
	always_comb
	begin
		cnt_start = 1'b0;
		cnt_stop  = !auto_mode;
		unique case (state_q)
			ref_sel_pkg::ST_STEADY:
				cnt_start = auto_mode && los_in[ref_select_out];
			ref_sel_pkg::ST_HOLDOFF:
				if (!los_in[ref_select_out] || (cnt_zero && !los_in[other]))
					cnt_stop = 1'b1;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			state_q <= ref_sel_pkg::ST_STEADY;
		else if (cnt_start)
			state_q <= ref_sel_pkg::ST_HOLDOFF;
		else if (cnt_stop)
			state_q <= ref_sel_pkg::ST_STEADY;
	end

	// fail-over needs a loss-free target; otherwise the counter reloads and tries again
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			ref_select_out <= 1'b0;
		else if (!auto_mode)
			ref_select_out <= manual_pick;
		else if (state_q == ref_sel_pkg::ST_HOLDOFF)
		begin
			if (cnt_zero && !los_in[other])
				ref_select_out <= other;
		end
		else if (revertive_switch_enable_q && revalidated && other == PREFERRED_INPUT && !cnt_start)
			ref_select_out <= other;
	end

	// manual holdover lasts until the new input is free of loss
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			holdover_out <= 1'b0;
		else if (!manual_holdover_disable_q)
		begin
			if (manual_pick != ref_select_out)
				holdover_out <= 1'b1;
			else if (!los_in[ref_select_out])
				holdover_out <= 1'b0;
		end
		else
		begin
			unique case (reference_selection_mode_q)
				ref_sel_pkg::MODE_MANUAL,
				ref_sel_pkg::MODE_AUTO:
					holdover_out <= 1'b0;
				ref_sel_pkg::MODE_SHORT_HOLD:
					holdover_out <= los_in[manual_pick];
				ref_sel_pkg::MODE_AUTO_HOLD:
					holdover_out <= cnt_start || (state_q == ref_sel_pkg::ST_HOLDOFF && !cnt_stop);
			endcase
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence manual_by_pin_s;
		!auto_mode && !src_int_q;
	endsequence

	sequence manual_by_reg_s;
		!auto_mode && src_int_q;
	endsequence

	sequence loss_on_selected_s;
		auto_mode && state_q == ref_sel_pkg::ST_STEADY && los_in[ref_select_out];
	endsequence

	pin_source_a: assert property (manual_by_pin_s |=> ref_select_out == $past(external_reference_pick_pin_in))
		else $error("pin source not followed");
	reg_pick_a: assert property (manual_by_reg_s |=> ref_select_out == $past(int_pick_q))
		else $error("register select bit not followed");
	auto_ignores_a: assert property (auto_mode && $stable(auto_mode) && !cnt_zero && !revalidated
		|=> $stable(ref_select_out))
		else $error("selection changed in automatic mode without cause");
	holdoff_starts_a: assert property (loss_on_selected_s |=> state_q == ref_sel_pkg::ST_HOLDOFF ##0 cnt_running)
		else $error("hold-off did not start on loss");
	failover_a: assert property (auto_mode && state_q == ref_sel_pkg::ST_HOLDOFF && cnt_zero
		&& !los_in[other] |=> ref_select_out != $past(ref_select_out))
		else $error("no fail-over at hold-off expiry");
	revert_off_a: assert property (auto_mode && !revertive_switch_enable_q
		&& state_q == ref_sel_pkg::ST_STEADY && revalidated |=> $stable(ref_select_out))
		else $error("revalidation switched with revertive off");
	revert_on_a: assert property (auto_mode && revertive_switch_enable_q
		&& state_q == ref_sel_pkg::ST_STEADY && revalidated && other == PREFERRED_INPUT && !cnt_start
		|=> ref_select_out == PREFERRED_INPUT)
		else $error("revertive switch did not happen");
	manual_holdover_a: assert property (!manual_holdover_disable_q && manual_pick != ref_select_out
		|=> holdover_out ##1 (holdover_out || !los_in[ref_select_out]))
		else $error("manual switch did not enter holdover");
	reset_values_a: assert property (disable iff (1'b0) !rst_n_in
		|=> !src_int_q && !revertive_switch_enable_q && !int_pick_q
		&& reference_selection_mode_q == ref_sel_pkg::MODE_MANUAL && holdoff_count_setting_q == 8'h80)
		else $error("register reset values wrong");

	sequence expiry_s;
		auto_mode && state_q == ref_sel_pkg::ST_HOLDOFF && cnt_zero;
	endsequence

	sequence short_hold_s;
		manual_holdover_disable_q && reference_selection_mode_q == ref_sel_pkg::MODE_SHORT_HOLD;
	endsequence

	// both inputs lost at expiry: stay put and let the counter run another period
	blocked_expiry_a: assert property (expiry_s ##0 los_in[other] |=> $stable(ref_select_out))
		else $error("switched onto a lost input");
	steady_idle_a: assert property (state_q == ref_sel_pkg::ST_STEADY |-> !cnt_running)
		else $error("hold-off counter running outside hold-off");
	start_load_a: assert property (cnt_start |=> cnt_value == $past(holdoff_count_setting_q))
		else $error("hold-off counter did not load its setting");

	no_holdover_a: assert property (manual_holdover_disable_q && !reference_selection_mode_q[1]
		|=> !holdover_out)
		else $error("holdover shown in a mode without holdover");
	short_clear_a: assert property (short_hold_s ##0 !los_in[manual_pick] |=> !holdover_out)
		else $error("short-term holdover shown without loss");
	short_set_a: assert property (short_hold_s ##0 los_in[manual_pick] |=> holdover_out)
		else $error("short-term holdover missing on loss");
	auto_hold_a: assert property (manual_holdover_disable_q
		&& reference_selection_mode_q == ref_sel_pkg::MODE_AUTO_HOLD && cnt_start |=> holdover_out)
		else $error("automatic holdover missing in hold-off");
	revert_manual_a: assert property (!auto_mode && revertive_switch_enable_q && revalidated
		|=> ref_select_out == $past(manual_pick))
		else $error("revertive setting acted in a manual mode");
endmodule

/* File: bench/ref_input_model.sv */
// Purpose: far side of the selector: loss flags of the two reference inputs and the select pin
// Assumes: flags are synchronous to clk_in, high = lost
// Notes:   slow_in holds back revalidation for a few cycles, as a real monitor would
`timescale 1ns/1ns

module ref_input_model (
	input  wire logic       clk_in,
	input  wire logic [1:0] los_cmd_in,
	input  wire logic       pick_cmd_in,
	input  wire logic       slow_in,
	output logic      [1:0] los_out,
	output logic            pick_pin_out
);
	logic [2:0] wait_q;

	initial
	begin
		los_out = 2'h0;
		pick_pin_out = 1'b0;
		wait_q = 3'h0;
	end

	always @(posedge clk_in)
	begin
		pick_pin_out <= pick_cmd_in;
		// a loss shows at once unless a clearing is being held back, which delays both; a clearing only once revalidation has run
		if ((los_out & ~los_cmd_in) == 2'h0 || !slow_in || wait_q == 3'h4)
		begin
			los_out <= los_cmd_in;
			wait_q <= 3'h0;
		end
		else
			wait_q <= wait_q + 3'h1;
	end
endmodule

/* File: bench/testbench.sv */
// Purpose: self-checking bench of the reference input selector
// Assumes: tick base shortened to 2^2 clocks, so divider 00 gives a tick every 4 cycles
// Notes:   bus tasks are AHB-Lite single word transfers
`timescale 1ns/1ns

module testbench;
	logic        clk;
	logic        rst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic        ref_sel;
	logic        holdover;
	logic [1:0]  los_cmd;
	logic        pick_cmd;
	logic        slow;
	logic [1:0]  los;
	logic        pin;
	logic [31:0] seed;
	logic [31:0] r;
	logic        s;
	int          n_mismatch;
	int          total_checks;

	reference_input_selector #(.TICK_BASE_LOG2(2)) i_dut (
		.clk_in                         (clk),
		.rst_n_in                       (rst_n),
		.hsel_in                        (hsel),
		.haddr_in                       (haddr),
		.htrans_in                      (htrans),
		.hwrite_in                      (hwrite),
		.hsize_in                       (hsize),
		.hwdata_in                      (hwdata),
		.hready_in                      (hreadyout),
		.hreadyout_out                  (hreadyout),
		.hresp_out                      (hresp),
		.hrdata_out                     (hrdata),
		.external_reference_pick_pin_in (pin),
		.los_in                         (los),
		.ref_select_out                 (ref_sel),
		.holdover_out                   (holdover)
	);

	ref_input_model i_far (
		.clk_in       (clk),
		.los_cmd_in   (los_cmd),
		.pick_cmd_in  (pick_cmd),
		.slow_in      (slow),
		.los_out      (los),
		.pick_pin_out (pin)
	);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic exp_manual(input logic src, input logic pin_v, input logic pick);
		return src ? pick : pin_v;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				check("bus timeout", 32'h1, 32'h0);
				wrap_up();
			end
			@(posedge clk);
		end
	endtask

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask

	task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		bus(1'b0, a, 32'h0, rd);
		check(what, rd, exp);
		check("bus response", {31'h0, hresp}, 32'h0);
	endtask

	// bounded wait for the selection to settle on exp
	task automatic wait_sel(input logic exp, input int bound);
		int n;
		n = 0;
		while (ref_sel !== exp && n < bound)
		begin
			@(posedge clk);
			n++;
		end
		check("ref select", {31'h0, ref_sel}, {31'h0, exp});
	endtask

	initial
	begin
		seed = 32'h4374CDB2;
		n_mismatch = 0;
		total_checks = 0;
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		los_cmd = 2'h0;
		pick_cmd = 1'b0;
		slow = 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check("sel after reset", {31'h0, ref_sel}, 32'h0);
		rdchk("source ctrl", 32'h080, 32'h2);
		rdchk("mode reg", 32'h084, 32'h0);
		rdchk("holdoff reg", 32'h088, 32'h80);
		rdchk("tick div reg", 32'h08C, 32'h80);
		rdchk("unmapped", 32'h0FC, 32'h0);
		// manual modes 00 and 10 with random source, pin, pick and revertive bit
		for (int i = 0; i < 8; i++)
		begin
			r = $random(seed);
			pick_cmd <= r[0];
			wr(32'h080, {30'h0, 1'b1, r[1]});
			wr(32'h084, {27'h0, r[4], r[2], 2'h0, r[3]});
			repeat (3) @(posedge clk);
			check("manual pick", {31'h0, ref_sel}, {31'h0, exp_manual(r[1], r[0], r[3])});
		end
		wr(32'h080, 32'h3);
		wr(32'h084, 32'h0);
		wr(32'h088, 32'h4);
		wr(32'h08C, 32'h0);
		rdchk("holdoff readback", 32'h088, 32'h4);
		wait_sel(1'b0, 4);
		s = 1'b0;
		// fail-over in mode 01 then mode 11; the pick bit points the other way and must not matter
		for (int m = 1; m < 4; m += 2)
		begin
			wr(32'h084, {28'h0, m[1:0], 1'b0, ~s});
			los_cmd[s] <= 1'b1;
			repeat (5) @(posedge clk);
			check("held during holdoff", {31'h0, ref_sel}, {31'h0, s});
			check("holdover flag", {31'h0, holdover}, {31'h0, m == 3});
			wait_sel(~s, 40);
			los_cmd[s] <= 1'b0;
			repeat (12) @(posedge clk);
			check("no revert", {31'h0, ref_sel}, {31'h0, ~s});
			rdchk("status", 32'h0A0, {16'h0, 8'h04, 7'h0, ~s});
			s = ~s;
		end
		wr(32'h084, 32'h14);
		los_cmd[0] <= 1'b1;
		wait_sel(1'b1, 40);
		slow <= 1'b1;
		los_cmd[0] <= 1'b0;
		wait_sel(1'b0, 20);
		// manual mode 10 ignores the revertive bit
		wr(32'h084, 32'h19);
		wait_sel(1'b1, 4);
		los_cmd[1] <= 1'b1;
		repeat (3) @(posedge clk);
		check("short holdover", {31'h0, holdover}, 32'h1);
		los_cmd[1] <= 1'b0;
		los_cmd[0] <= 1'b1;
		repeat (6) @(posedge clk);
		los_cmd[0] <= 1'b0;
		repeat (12) @(posedge clk);
		check("mode 10 no revert", {31'h0, ref_sel}, 32'h1);
		// holdover on a manual switch onto a lost input, mode field ignored
		los_cmd[0] <= 1'b1;
		wr(32'h080, 32'h1);
		wr(32'h084, 32'h04);
		repeat (3) @(posedge clk);
		check("manual switch", {31'h0, ref_sel}, 32'h0);
		check("manual holdover", {31'h0, holdover}, 32'h1);
		los_cmd[0] <= 1'b0;
		repeat (9) @(posedge clk);
		check("holdover ends", {31'h0, holdover}, 32'h0);
		wrap_up();
	end
endmodule
